// ---- verilog/ca_training_defines.svh ----
// offsets, field positions, reset values and timing counts of the training block
`ifndef CA_TRAINING_DEFINES_SVH
`define CA_TRAINING_DEFINES_SVH

// ==========================================
// register offsets (byte addresses)
`define OFS_MODE_FIRST   8'h00
`define OFS_MODE_SECOND  8'h04
`define OFS_STATUS       8'h08
`define OFS_CONFIG       8'h0c

// ==========================================
// mode register selectors in the second half
`define SEL_SET_POINT    2'h0
`define SEL_CA_REF       2'h1
`define SEL_TERM         2'h2
`define SEL_TERM_EXTRA   2'h3

// ==========================================
// field positions
`define SPC_TRAIN_EN     0
`define SPC_WRITE_SP     6
`define SPC_OPER_SP      7
`define EXTRA_PAD_OFF    5

// ==========================================
// reset values
`define SPC_RESET        8'h00
`define CA_REF_RESET     8'h4d
`define TERM_RESET       8'h00
`define EXTRA_RESET      8'h00

// ==========================================
// timing in ns, and cycle counts rounded up
`define CLK_PERIOD_NS    100
`define MODE_WR_DELAY_NS 20
`define ENTRY_DELAY_NS   250
`define MODE_WR_DONE_NS  20
`define MODE_WR_DELAY_CYC ((`MODE_WR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ENTRY_DELAY_CYC   ((`ENTRY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_WR_DONE_CYC  ((`MODE_WR_DONE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- verilog/ca_training_pkg.sv ----
// types of the command-address training block
`default_nettype none
package ca_training_pkg;

    // ==========================================
    // training phases
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ARM_WAIT,
        PH_ARMED,
        PH_ENTRY_WAIT,
        PH_TRAIN,
        PH_EXITED,
        PH_EXIT_WAIT
    } phase_type;

    // ==========================================
    // whole state of the block
    typedef struct packed {
        logic [2:0]  ck_sh;
        logic [2:0]  cke_sh;
        logic [2:0]  dqs_sh;
        logic [1:0]  cs_sh;
        logic [5:0]  ca_s1;
        logic [5:0]  ca_s2;
        logic [6:0]  dq_s1;
        logic [6:0]  dq_s2;
        phase_type   phase;
        logic [7:0]  tmr;
        logic [7:0]  op_stage;
        logic [7:0]  spc;
        logic [7:0]  ca_ref;
        logic [7:0]  term;
        logic [7:0]  extra;
        logic [6:0]  vref_act;
        logic        osp;
        logic [5:0]  fb;
        logic        ready;
        logic        dq_term;
        logic        ca_term;
        logic [15:0] dq_out;
        logic [15:0] dq_oe;
        logic [31:0] rdata;
    } dev_state_type;

endpackage
`default_nettype wire

// ---- verilog/ca_training.sv ----
// command-address bus training logic of one memory die
//
// Implementation choices: the plain strobed port and the register addresses.
`include "ca_training_defines.svh"
`default_nettype none

module ca_training
    import ca_training_pkg::*;
(
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    // register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    // link pins from the controller
    input  wire logic        CK,
    input  wire logic        CKE,
    input  wire logic        CS,
    input  wire logic [5:0]  CA,
    input  wire logic        DQS0,
    input  wire logic [15:0] DQ_IN,
    // data pins driven by the die
    output logic      [15:0] DQ_OUT,
    output logic      [15:0] DQ_OE,
    // status towards the die
    output logic             OPER_SET_POINT,
    output logic      [6:0]  CA_VREF,
    output logic             DQ_TERM_EN,
    output logic             CA_TERM_EN,
    output logic             NORMAL_READY
);

    // ==========================================
    // state and edge detection
    dev_state_type st_reg;
    dev_state_type st_next;
    logic          ck_rise;
    logic          cke_fall;
    logic          cke_rise;
    logic          dqs_rise;
    logic          commit;
    logic          in_cbt;

    assign ck_rise  = st_reg.ck_sh[1] & ~st_reg.ck_sh[2];
    assign cke_fall = ~st_reg.cke_sh[1] & st_reg.cke_sh[2];
    assign cke_rise = st_reg.cke_sh[1] & ~st_reg.cke_sh[2];
    assign dqs_rise = st_reg.dqs_sh[1] & ~st_reg.dqs_sh[2];
    assign commit   = REG_WR && (REG_ADDR == `OFS_MODE_SECOND);
    assign in_cbt   = (st_reg.phase == PH_ENTRY_WAIT) || (st_reg.phase == PH_TRAIN);

    // ==========================================
    // next state
    always_comb begin
        st_next = st_reg;
        st_next.ck_sh  = {st_reg.ck_sh[1:0], CK};
        st_next.cke_sh = {st_reg.cke_sh[1:0], CKE};
        st_next.dqs_sh = {st_reg.dqs_sh[1:0], DQS0};
        st_next.cs_sh  = {st_reg.cs_sh[0], CS};
        st_next.ca_s1  = CA;
        st_next.ca_s2  = st_reg.ca_s1;
        st_next.dq_s1  = DQ_IN[6:0];
        st_next.dq_s2  = st_reg.dq_s1;
        if (st_reg.tmr != 8'h00) begin
            st_next.tmr = st_reg.tmr - 8'h01;
        end
        // first half stages the operand
        if (REG_WR && (REG_ADDR == `OFS_MODE_FIRST)) begin
            st_next.op_stage = REG_WDATA[7:0];
        end
        // second half commits to the selected register
        if (commit) begin
            case (REG_WDATA[1:0])
                `SEL_SET_POINT: begin
                    st_next.spc = st_reg.op_stage;
                    if (st_reg.op_stage[`SPC_TRAIN_EN] && st_reg.cke_sh[1]
                        && (st_reg.phase == PH_IDLE)) begin
                        st_next.phase = PH_ARM_WAIT;
                        st_next.tmr   = 8'(`MODE_WR_DELAY_CYC);
                        st_next.ready = 1'b0;
                    end else if (!st_reg.op_stage[`SPC_TRAIN_EN]) begin
                        if ((st_reg.phase == PH_ARM_WAIT) || (st_reg.phase == PH_ARMED)) begin
                            st_next.phase = PH_IDLE;
                            st_next.ready = 1'b1;
                        end else if (st_reg.phase == PH_EXITED) begin
                            st_next.phase = PH_EXIT_WAIT;
                            st_next.tmr   = 8'(`MODE_WR_DONE_CYC);
                        end
                    end
                    if (st_reg.phase == PH_IDLE) begin
                        st_next.osp = st_reg.op_stage[`SPC_OPER_SP];
                    end
                end
                `SEL_CA_REF: begin
                    st_next.ca_ref = st_reg.op_stage;
                end
                `SEL_TERM: begin
                    st_next.term = st_reg.op_stage;
                end
                default: begin
                    st_next.extra = st_reg.op_stage;
                end
            endcase
        end
        case (st_reg.phase)
            PH_IDLE: begin
                st_next.vref_act = st_next.ca_ref[6:0];
            end
            PH_ARM_WAIT: begin
                if (st_reg.tmr == 8'h00 && st_next.phase == PH_ARM_WAIT) begin
                    st_next.phase = PH_ARMED;
                end
            end
            PH_ARMED: begin
                // low CKE switches to alternate set point
                if (cke_fall && st_next.phase == PH_ARMED) begin
                    st_next.phase    = PH_ENTRY_WAIT;
                    st_next.tmr      = 8'(`ENTRY_DELAY_CYC);
                    st_next.osp      = ~st_reg.spc[`SPC_OPER_SP];
                    st_next.vref_act = st_reg.ca_ref[6:0];
                end
            end
            PH_ENTRY_WAIT, PH_TRAIN: begin
                if (st_reg.phase == PH_ENTRY_WAIT && st_reg.tmr == 8'h00) begin
                    st_next.phase = PH_TRAIN;
                end
                // bit n of DQ to bit n of reference
                // change only on a rising strobe edge, or on CKE rise at exit
                if (st_reg.phase == PH_TRAIN && dqs_rise) begin
                    st_next.vref_act = st_reg.dq_s2;
                end
                // CA levels latched with CS fed back
                if (ck_rise && st_reg.cs_sh[1]) begin
                    st_next.fb = st_reg.ca_s2;
                end
                if (cke_rise) begin
                    st_next.phase    = PH_EXITED;
                    st_next.osp      = st_reg.spc[`SPC_OPER_SP];
                    st_next.vref_act = st_reg.ca_ref[6:0];
                end
            end
            PH_EXITED: begin
                st_next.vref_act = st_next.ca_ref[6:0];
            end
            PH_EXIT_WAIT: begin
                if (st_reg.tmr == 8'h00) begin
                    st_next.phase = PH_IDLE;
                    st_next.ready = 1'b1;
                end
            end
            default: begin
                st_next.phase = PH_IDLE;
            end
        endcase
        if ((st_next.phase == PH_ENTRY_WAIT) || (st_next.phase == PH_TRAIN)) begin
            st_next.dq_out = {2'b00, st_next.fb, 8'h00};
            st_next.dq_oe  = 16'h3f00;
        end else begin
            st_next.dq_out = 16'h0000;
            st_next.dq_oe  = 16'h0000;
        end
        st_next.dq_term = ((st_next.phase == PH_ENTRY_WAIT) || (st_next.phase == PH_TRAIN))
                          && (st_next.term[2:0] != 3'h0);
        st_next.ca_term = (st_next.term[6:4] != 3'h0) && !st_next.extra[`EXTRA_PAD_OFF];
        // read data one cycle after the strobe
        st_next.rdata = 32'h0000_0000;
        if (REG_RD) begin
            case (REG_ADDR)
                `OFS_MODE_FIRST:  st_next.rdata = {24'h00_0000, st_reg.op_stage};
                `OFS_STATUS:      st_next.rdata = {9'h000, st_reg.vref_act, 2'h0, st_reg.fb,
                                                   4'h0, st_reg.phase == PH_TRAIN, st_reg.ready,
                                                   st_reg.osp, in_cbt};
                `OFS_CONFIG:      st_next.rdata = {st_reg.extra, st_reg.term,
                                                   st_reg.ca_ref, st_reg.spc};
                default:          st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            // power-up on operating set point zero
            st_reg          <= '0;
            st_reg.spc      <= `SPC_RESET;
            st_reg.ca_ref   <= `CA_REF_RESET;
            st_reg.term     <= `TERM_RESET;
            st_reg.extra    <= `EXTRA_RESET;
            st_reg.cke_sh   <= 3'h7;
            st_reg.vref_act <= 7'(`CA_REF_RESET);
            st_reg.ready    <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign REG_RDATA      = st_reg.rdata;
    assign DQ_OUT         = st_reg.dq_out;
    assign DQ_OE          = st_reg.dq_oe;
    assign OPER_SET_POINT = st_reg.osp;
    assign CA_VREF        = st_reg.vref_act;
    assign DQ_TERM_EN     = st_reg.dq_term;
    assign CA_TERM_EN     = st_reg.ca_term;
    assign NORMAL_READY   = st_reg.ready;

    // ==========================================
    // assertions
    property p_reset_osp;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        $past(SYS_RST) |-> (OPER_SET_POINT == 1'b0) && NORMAL_READY;
    endproperty
    a_reset_osp: assert property (p_reset_osp) else $error("set point not zero after reset");

    property p_entry;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (st_reg.phase == PH_ARMED && cke_fall && !commit)
        |=> (OPER_SET_POINT == ~$past(st_reg.spc[7])) ##1 (DQ_OE[13:8] == 6'h3f);
    endproperty
    a_entry: assert property (p_entry) else $error("entry did not switch set point");

    property p_capture;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (st_reg.phase == PH_TRAIN && dqs_rise && !cke_rise) |=> (CA_VREF == $past(st_reg.dq_s2));
    endproperty
    a_capture: assert property (p_capture) else $error("strobe did not load reference");

    property p_hold;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (in_cbt && !dqs_rise && !cke_rise) |=> $stable(CA_VREF);
    endproperty
    a_hold: assert property (p_hold) else $error("reference changed without strobe");

    property p_entry_delay;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (st_reg.phase == PH_ARMED && cke_fall && !commit) |=> (st_reg.phase != PH_TRAIN)[*3];
    endproperty
    a_entry_delay: assert property (p_entry_delay) else $error("capture before entry delay");

    property p_upper_float;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        1'b1 |-> (DQ_OE[15:14] == 2'b00) && (DQ_OE[7:0] == 8'h00);
    endproperty
    a_upper_float: assert property (p_upper_float) else $error("unexpected lane driven");

    property p_feedback;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (in_cbt && ck_rise && st_reg.cs_sh[1] && !cke_rise)
        |=> ##1 (DQ_OUT[13:8] == $past(st_reg.ca_s2, 2));
    endproperty
    a_feedback: assert property (p_feedback) else $error("feedback lanes wrong");

    property p_exit;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (in_cbt && cke_rise) |=> (OPER_SET_POINT == $past(st_reg.spc[7]))
                                 && (CA_VREF == $past(st_reg.ca_ref[6:0]));
    endproperty
    a_exit: assert property (p_exit) else $error("exit did not restore set point");

    property p_ready;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (st_reg.phase == PH_EXIT_WAIT) |-> ##[1:3] NORMAL_READY;
    endproperty
    a_ready: assert property (p_ready) else $error("not ready after completion time");

    property p_dq_term;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        DQ_TERM_EN |-> (st_reg.term[2:0] != 3'h0) && (DQ_OE[13:8] == 6'h3f);
    endproperty
    a_dq_term: assert property (p_dq_term) else $error("termination outside training");

    c_entry: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        st_reg.phase == PH_ARMED ##1 st_reg.phase == PH_ENTRY_WAIT);
    c_capture: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        st_reg.phase == PH_TRAIN && dqs_rise);
    c_exit: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        st_reg.phase == PH_EXIT_WAIT ##[1:3] st_reg.phase == PH_IDLE);

endmodule
`default_nettype wire

// ---- tb/ca_ctl_model.sv ----
// controller-side model driving the training pins of the die
`default_nettype none
module ca_ctl_model (
    // link pins towards the die
    output logic        CK,
    output logic        CKE,
    output logic        CS,
    output logic [5:0]  CA,
    output logic        DQS0,
    output logic [15:0] DQ_IN,
    // data pins driven by the die
    input  wire logic [15:0] DQ_OUT,
    input  wire logic [15:0] DQ_OE
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] dq_drv;
    logic [8:0] float_pat;
    initial begin
        CK = 1'b0;
        CKE = 1'b1;
        CS = 1'b0;
        CA = 6'h00;
        DQS0 = 1'b0;
        dq_drv = 7'h00;
        float_pat = 9'h155;
    end
    // ==========================================
    // wire levels: undriven lanes wander, die lanes follow enables
    // floating lanes
    always #100 float_pat = ~float_pat;
    always_comb begin
        DQ_IN[6:0] = dq_drv;
        for (int i = 7; i < 16; i++) begin
            DQ_IN[i] = DQ_OE[i] ? DQ_OUT[i] : float_pat[i - 7];
        end
    end
    // ==========================================
    // link pin tasks
    task automatic cke_set(input logic v);
        CKE = v;
    endtask
    task automatic strobe(input logic [6:0] v);
        dq_drv = v;
        repeat (2) begin
            #300 DQS0 = 1'b1;
            #300 DQS0 = 1'b0;
        end
        #300 dq_drv = ~v;
        #300;
    endtask
    // one link clock frame with chip select high
    task automatic ca_send(input logic [5:0] v);
        CS = 1'b1;
        CA = v;
        #400 CK = 1'b1;
        #400 CK = 1'b0;
        CS = 1'b0;
        CA = 6'h00;
    endtask
endmodule
`default_nettype wire

// ---- tb/ca_training_tb_top.sv ----
// self-checking bench of the command-address training block
`include "ca_training_defines.svh"
`default_nettype none
module ca_training_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        SYS_CLK;
    logic        SYS_RST;
    logic [7:0]  REG_ADDR;
    logic [31:0] REG_WDATA;
    logic        REG_WR;
    logic        REG_RD;
    logic [31:0] REG_RDATA;
    logic        CK;
    logic        CKE;
    logic        CS;
    logic        DQS0;
    logic [5:0]  CA;
    logic [15:0] DQ_IN;
    logic [15:0] DQ_OUT;
    logic [15:0] DQ_OE;
    logic        OPER_SET_POINT;
    logic        DQ_TERM_EN;
    logic        CA_TERM_EN;
    logic        NORMAL_READY;
    logic [6:0]  CA_VREF;
    logic [31:0] d;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cycle_cnt = 0;

    ca_training DUT (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .CK(CK), .CKE(CKE), .CS(CS), .CA(CA), .DQS0(DQS0), .DQ_IN(DQ_IN),
        .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .OPER_SET_POINT(OPER_SET_POINT),
        .CA_VREF(CA_VREF), .DQ_TERM_EN(DQ_TERM_EN), .CA_TERM_EN(CA_TERM_EN),
        .NORMAL_READY(NORMAL_READY));
    ca_ctl_model P (.CK(CK), .CKE(CKE), .CS(CS), .CA(CA), .DQS0(DQS0), .DQ_IN(DQ_IN),
        .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE));

    // ==========================================
    // clock, timeout and shared tasks
    initial SYS_CLK = 1'b0;
    always #50 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cycle_cnt++;
        if (cycle_cnt == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge SYS_CLK);
        REG_ADDR  <= a;
        REG_WDATA <= v;
        REG_WR    <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD   <= 1'b0;
        @(negedge SYS_CLK);
        v = REG_RDATA;
    endtask
    task automatic mw(input logic [7:0] op, input logic [1:0] sel);
        wr(`OFS_MODE_FIRST, {24'h0, op});
        wr(`OFS_MODE_SECOND, {30'h0, sel});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        chk("set point", 32'(OPER_SET_POINT), 32'h0);
        chk("vref", 32'(CA_VREF), 32'h4d);
        chk("ready", 32'(NORMAL_READY), 32'h1);
        chk("enables", 32'(DQ_OE), 32'h0);
        rd(`OFS_CONFIG, d);
        chk("config", d, 32'h00004d00);
        rd(8'h10, d);
        chk("unmapped", d, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_term();
        mw(8'h13, `SEL_TERM);
        idle(3);
        chk("ca term on", 32'(CA_TERM_EN), 32'h1);
        mw(8'h20, `SEL_TERM_EXTRA);
        idle(3);
        chk("ca term off", 32'(CA_TERM_EN), 32'h0);
        mw(8'h03, `SEL_TERM);
        mw(8'h52, `SEL_CA_REF);
        idle(2);
        chk("vref reg", 32'(CA_VREF), 32'h52);
        rd(`OFS_MODE_FIRST, d);
        chk("staged", d, 32'h52);
        rd(`OFS_CONFIG, d);
        chk("config", d, 32'h20035200);
        mw(8'h4d, `SEL_CA_REF);
        idle(2);
        chk("vref restored", 32'(CA_VREF), 32'h4d);
        $display("test termination done");
    endtask
    task automatic t_entry();
        mw(8'h41, `SEL_SET_POINT);
        idle(2);
        chk("ready armed", 32'(NORMAL_READY), 32'h0);
        P.cke_set(1'b0);
        idle(6);
        chk("set point", 32'(OPER_SET_POINT), 32'h1);
        chk("enables", 32'(DQ_OE), 32'h3f00);
        chk("dq term", 32'(DQ_TERM_EN), 32'h1);
        chk("vref kept", 32'(CA_VREF), 32'h4d);
        $display("test entry done");
    endtask
    task automatic t_vref();
        idle(4);
        P.strobe(7'h25);
        idle(1);
        chk("vref a", 32'(CA_VREF), 32'h25);
        P.strobe(7'h5a);
        idle(1);
        chk("vref b", 32'(CA_VREF), 32'h5a);
        $display("test reference done");
    endtask
    task automatic t_feedback();
        P.ca_send(6'h2b);
        idle(8);
        chk("feedback", 32'(DQ_OUT), 32'h2b00);
        rd(`OFS_STATUS, d);
        chk("status", d, 32'h005a2b0b);
        P.ca_send(6'h14);
        idle(8);
        chk("feedback", 32'(DQ_OUT), 32'h1400);
        $display("test feedback done");
    endtask
    task automatic t_exit();
        // exit by CKE then clear enable
        P.cke_set(1'b1);
        idle(6);
        chk("set point back", 32'(OPER_SET_POINT), 32'h0);
        chk("vref dropped", 32'(CA_VREF), 32'h4d);
        chk("released", 32'(DQ_OE), 32'h0);
        chk("dq term off", 32'(DQ_TERM_EN), 32'h0);
        idle(3);
        mw(8'h40, `SEL_SET_POINT);
        idle(3);
        chk("ready", 32'(NORMAL_READY), 32'h1);
        $display("test exit done");
    endtask
    task automatic t_alt();
        mw(8'h80, `SEL_SET_POINT);
        idle(2);
        chk("set point one", 32'(OPER_SET_POINT), 32'h1);
        mw(8'hc1, `SEL_SET_POINT);
        idle(2);
        P.cke_set(1'b0);
        idle(6);
        chk("alternate", 32'(OPER_SET_POINT), 32'h0);
        P.cke_set(1'b1);
        idle(6);
        chk("reverted", 32'(OPER_SET_POINT), 32'h1);
        idle(3);
        mw(8'hc0, `SEL_SET_POINT);
        idle(3);
        chk("ready", 32'(NORMAL_READY), 32'h1);
        $display("test alternate done");
    endtask
    task automatic t_refuse();
        P.cke_set(1'b0);
        idle(4);
        mw(8'h01, `SEL_SET_POINT);
        idle(6);
        chk("no entry", 32'(DQ_OE), 32'h0);
        chk("no arm", 32'(NORMAL_READY), 32'h1);
        mw(8'h00, `SEL_SET_POINT);
        P.cke_set(1'b1);
        idle(4);
        mw(8'h01, `SEL_SET_POINT);
        idle(2);
        chk("armed", 32'(NORMAL_READY), 32'h0);
        mw(8'h00, `SEL_SET_POINT);
        idle(2);
        chk("cancelled", 32'(NORMAL_READY), 32'h1);
        $display("test refuse done");
    endtask
    task automatic t_rerun();
        mw(8'h80, `SEL_SET_POINT);
        @(posedge SYS_CLK);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        idle(4);
        chk("set point", 32'(OPER_SET_POINT), 32'h0);
        chk("vref", 32'(CA_VREF), 32'h4d);
        chk("ready", 32'(NORMAL_READY), 32'h1);
        rd(`OFS_CONFIG, d);
        chk("config", d, 32'h00004d00);
        $display("test second reset done");
    endtask

    initial begin
        SYS_RST   = 1'b1;
        REG_ADDR  = 8'h00;
        REG_WDATA = 32'h0;
        REG_WR    = 1'b0;
        REG_RD    = 1'b0;
        repeat (4) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        idle(4);
        t_reset();
        t_term();
        t_entry();
        t_vref();
        t_feedback();
        t_exit();
        t_alt();
        t_refuse();
        t_rerun();
        close_out();
    end
endmodule
`default_nettype wire
